// File: core/sdram_cmd_params.svh
// Timing counts and pin encodings for the command and state control block
`ifndef SDRAM_CMD_PARAMS_SVH
`define SDRAM_CMD_PARAMS_SVH
`define CLK_PERIOD_NS      50
`define PRECHARGE_NS       20
`define ACT_ACCESS_NS      20
`define REFRESH_CYCLE_NS   70
`define MODE_LOAD_NS       14
`define SELF_REF_EXIT_NS   80
// Least times round up to whole cycles, never below one
`define CYC_UP(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS < 1 ? 1 : \
                   ((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PRECHARGE_CYC      `CYC_UP(`PRECHARGE_NS)
`define ACT_ACCESS_CYC     `CYC_UP(`ACT_ACCESS_NS)
`define REFRESH_CYCLE_CYC  `CYC_UP(`REFRESH_CYCLE_NS)
`define MODE_LOAD_CYC      `CYC_UP(`MODE_LOAD_NS)
`define SELF_REF_EXIT_CYC  `CYC_UP(`SELF_REF_EXIT_NS)
`define MIN_EXIT_NOPS      2
`define AP_BIT             10
`define BANK_COUNT         4
`define CNT_W              8
`endif

// File: core/sdram_cmd_pkg.sv
// Types shared by both ends of the command link
package sdram_cmd_pkg;
  typedef enum logic [3:0] {
    CMD_INHIBIT = 4'h0, CMD_NOP = 4'h1, CMD_ACTIVE = 4'h2, CMD_READ = 4'h3,
    CMD_WRITE = 4'h4, CMD_PRECHARGE = 4'h5, CMD_REFRESH = 4'h6,
    CMD_LOAD_MODE = 4'h7, CMD_TERMINATE = 4'h8, CMD_ILLEGAL = 4'h9
  } cmd_t;
  typedef enum logic [7:0] {
    BK_IDLE = 8'h01, BK_ACTIVATING = 8'h02, BK_ACTIVE = 8'h04, BK_READ = 8'h08,
    BK_WRITE = 8'h10, BK_READ_AP = 8'h20, BK_WRITE_AP = 8'h40, BK_PRECHARGING = 8'h80
  } bank_state_t;
  typedef enum logic [6:0] {
    DV_NORMAL = 7'h01, DV_POWER_DOWN = 7'h02, DV_SELF_REFRESH = 7'h04,
    DV_SR_EXIT = 7'h08, DV_SUSPEND = 7'h10, DV_REFRESHING = 7'h20, DV_MODE_LOAD = 7'h40
  } dev_state_t;
endpackage

// File: core/sdram_cmd_if.sv
// Command pins between memory controller and device
`timescale 1ns/100ps
interface sdram_cmd_if;
  logic        clock_enable;
  logic        chip_select_n;
  logic        row_strobe_n;
  logic        column_strobe_n;
  logic        write_enable_n;
  logic [1:0]  bank_addr;
  logic [11:0] addr;
  modport device (input clock_enable, chip_select_n, row_strobe_n, column_strobe_n,
                  write_enable_n, bank_addr, addr);
  modport controller (output clock_enable, chip_select_n, row_strobe_n,
                      column_strobe_n, write_enable_n, bank_addr, addr);
endinterface

// File: core/sdram_bank_fsm.sv
// One bank's state tracker with its own interval counter
`timescale 1ns/100ps
`include "sdram_cmd_params.svh"
module sdram_bank_fsm #(
  parameter int CNT_W = `CNT_W
) (
  input  wire logic                        ref_clk_in,
  input  wire logic                        srst_in,
  input  wire logic                        live_in,
  input  wire sdram_cmd_pkg::cmd_t         cmd_in,
  input  wire logic                        hit_in,
  input  wire logic                        all_in,
  input  wire logic                        auto_pre_in,
  input  wire logic                        term_in,
  output      sdram_cmd_pkg::bank_state_t  state_out
);
  localparam logic [CNT_W-1:0] PRE_CNT = CNT_W'(`PRECHARGE_CYC);
  localparam logic [CNT_W-1:0] ACT_CNT = CNT_W'(`ACT_ACCESS_CYC);
  logic [CNT_W-1:0] count;
  logic             count_done;
  assign count_done = (count <= CNT_W'(1));

  // Bank state and interval counter advance together
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      state_out <= sdram_cmd_pkg::BK_IDLE;
      count     <= '0;
    end
    else if (live_in)
    begin
      if (count != '0)
        count <= count - CNT_W'(1);
      case (state_out)
        sdram_cmd_pkg::BK_IDLE:
        begin
          if (hit_in && cmd_in == sdram_cmd_pkg::CMD_ACTIVE)
          begin
            state_out <= sdram_cmd_pkg::BK_ACTIVATING;
            count     <= ACT_CNT;
          end
          // Precharge of an idle bank acts as no-op here
        end
        sdram_cmd_pkg::BK_ACTIVATING, sdram_cmd_pkg::BK_PRECHARGING,
        sdram_cmd_pkg::BK_READ_AP, sdram_cmd_pkg::BK_WRITE_AP:
        begin
          if (count_done)
            state_out <= (state_out == sdram_cmd_pkg::BK_ACTIVATING) ?
                         sdram_cmd_pkg::BK_ACTIVE : sdram_cmd_pkg::BK_IDLE;
        end
        default:
        begin
          // Row active, read or write without auto precharge
          if ((hit_in || all_in) && cmd_in == sdram_cmd_pkg::CMD_PRECHARGE)
          begin
            state_out <= sdram_cmd_pkg::BK_PRECHARGING;
            count     <= PRE_CNT;
          end
          else if (hit_in && (cmd_in == sdram_cmd_pkg::CMD_READ ||
                              cmd_in == sdram_cmd_pkg::CMD_WRITE))
          begin
            // Both auto precharge variants accepted
            if (auto_pre_in)
            begin
              state_out <= (cmd_in == sdram_cmd_pkg::CMD_READ) ?
                           sdram_cmd_pkg::BK_READ_AP : sdram_cmd_pkg::BK_WRITE_AP;
              count     <= PRE_CNT;
            end
            else
              state_out <= (cmd_in == sdram_cmd_pkg::CMD_READ) ?
                           sdram_cmd_pkg::BK_READ : sdram_cmd_pkg::BK_WRITE;
          end
          else if (term_in && state_out != sdram_cmd_pkg::BK_ACTIVE)
            state_out <= sdram_cmd_pkg::BK_ACTIVE;
        end
      endcase
    end
  end
endmodule

// File: core/sdram_cmd_device.sv
// Device end: clock enable history, command decode and bank states
// Notes on behaviour
// - Low clock enable twice keeps low-power state
// - Falling enable enters power-down, self refresh, suspend
// - Power-down exit idle by next edge
// - Self refresh exit idles after exit time
// - Controller sends only no-ops during exit time
// - Suspend exit resumes; next command at n+1
// - Controller sends only permitted sequences
// - Inhibit and no-op continue previous operation
// - Decode active, refresh, mode load, precharge
// - Active bank accepts read, write, precharge
// - Read burst accepts read, write, terminate, precharge
// - Write burst accepts read, write, terminate, precharge
// - Precharge of idle bank is a no-op
// - Refresh and mode load need all idle
// - Terminate stops most recent burst, any bank
// - Precharge-all only from valid bank states
// - Idle after precharge period; active after delay
// - No commands to a busy bank
// - Auto precharge states end idle after period
// - Only no-ops during refresh, mode load
// - Bank decode only with enable high twice
// - Both auto precharge variants accepted
`timescale 1ns/100ps
`include "sdram_cmd_params.svh"
module sdram_cmd_device #(
  parameter int BANKS = `BANK_COUNT,
  parameter int CNT_W = `CNT_W
) (
  input  wire logic                        ref_clk_in,
  input  wire logic                        srst_in,
  sdram_cmd_if.device                      link,
  output      sdram_cmd_pkg::dev_state_t   dev_state_out,
  output      sdram_cmd_pkg::cmd_t         cmd_out,
  output      logic [BANKS-1:0]            bank_idle_out,
  output      logic                        protocol_error_out
);
  localparam logic [CNT_W-1:0] RFC_CNT = CNT_W'(`REFRESH_CYCLE_CYC);
  localparam logic [CNT_W-1:0] MRD_CNT = CNT_W'(`MODE_LOAD_CYC);
  localparam logic [CNT_W-1:0] XSR_CNT = CNT_W'(`SELF_REF_EXIT_CYC);
  localparam logic [2:0]       MIN_NOPS = 3'(`MIN_EXIT_NOPS);

  // Pins come from the other party: two stages before use
  logic       cke_s1, cke_s2, cke_prev;
  logic [3:0] cmd_s1, cmd_s2;
  logic [1:0] ba_s1, ba_s2;
  logic [11:0] a_s1, a_s2;
  always_ff @(posedge ref_clk_in)
  begin
    cke_s1   <= link.clock_enable;
    cke_s2   <= cke_s1;
    cke_prev <= srst_in ? 1'b0 : cke_s2;
    cmd_s1   <= {link.chip_select_n, link.row_strobe_n,
                 link.column_strobe_n, link.write_enable_n};
    cmd_s2   <= cmd_s1;
    ba_s1    <= link.bank_addr;
    ba_s2    <= ba_s1;
    a_s1     <= link.addr;
    a_s2     <= a_s1;
  end

  // Pin decode
  sdram_cmd_pkg::cmd_t cmd;
  always_comb
  begin
    if (cmd_s2[3])
      cmd = sdram_cmd_pkg::CMD_INHIBIT;
    else
    begin
      case (cmd_s2[2:0])
        3'h7:    cmd = sdram_cmd_pkg::CMD_NOP;
        3'h3:    cmd = sdram_cmd_pkg::CMD_ACTIVE;
        3'h1:    cmd = sdram_cmd_pkg::CMD_REFRESH;
        3'h0:    cmd = sdram_cmd_pkg::CMD_LOAD_MODE;
        3'h2:    cmd = sdram_cmd_pkg::CMD_PRECHARGE;
        3'h5:    cmd = sdram_cmd_pkg::CMD_READ;
        3'h4:    cmd = sdram_cmd_pkg::CMD_WRITE;
        3'h6:    cmd = sdram_cmd_pkg::CMD_TERMINATE;
        default: cmd = sdram_cmd_pkg::CMD_ILLEGAL;
      endcase
    end
  end

  logic nop_like;
  assign nop_like = (cmd == sdram_cmd_pkg::CMD_INHIBIT) || (cmd == sdram_cmd_pkg::CMD_NOP);

  sdram_cmd_pkg::bank_state_t bank_st [BANKS];
  logic all_idle, any_burst, any_busy, live;
  logic [CNT_W-1:0] dcount;
  logic [2:0]       nop_count;
  logic [1:0]       last_burst_bank;

  always_comb
  begin
    all_idle  = 1'b1;
    any_burst = 1'b0;
    any_busy  = 1'b0;
    for (int i = 0; i < BANKS; i++)
    begin
      all_idle  &= (bank_st[i] == sdram_cmd_pkg::BK_IDLE);
      any_burst |= (bank_st[i] == sdram_cmd_pkg::BK_READ) ||
                   (bank_st[i] == sdram_cmd_pkg::BK_WRITE) ||
                   (bank_st[i] == sdram_cmd_pkg::BK_READ_AP) ||
                   (bank_st[i] == sdram_cmd_pkg::BK_WRITE_AP);
      any_busy  |= (bank_st[i] == sdram_cmd_pkg::BK_ACTIVATING) ||
                   (bank_st[i] == sdram_cmd_pkg::BK_PRECHARGING) ||
                   (bank_st[i] == sdram_cmd_pkg::BK_READ_AP) ||
                   (bank_st[i] == sdram_cmd_pkg::BK_WRITE_AP);
    end
  end

  // Bank decode only with enable high at both edges in normal state
  assign live = cke_prev && cke_s2 && (dev_state_out == sdram_cmd_pkg::DV_NORMAL);

  // Device-wide state on enable history
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      dev_state_out <= sdram_cmd_pkg::DV_NORMAL;
      dcount        <= '0;
      nop_count     <= '0;
    end
    else
    begin
      if (dcount != '0)
        dcount <= dcount - CNT_W'(1);
      case (dev_state_out)
        sdram_cmd_pkg::DV_NORMAL:
        begin
          if (cke_prev && !cke_s2)
          begin
            if (all_idle && nop_like)
              dev_state_out <= sdram_cmd_pkg::DV_POWER_DOWN;
            else if (all_idle && cmd == sdram_cmd_pkg::CMD_REFRESH)
              dev_state_out <= sdram_cmd_pkg::DV_SELF_REFRESH;
            else if (any_burst)
              dev_state_out <= sdram_cmd_pkg::DV_SUSPEND;
          end
          else if (live && cmd == sdram_cmd_pkg::CMD_REFRESH && all_idle)
          begin
            dev_state_out <= sdram_cmd_pkg::DV_REFRESHING;
            dcount        <= RFC_CNT;
          end
          else if (live && cmd == sdram_cmd_pkg::CMD_LOAD_MODE && all_idle)
          begin
            dev_state_out <= sdram_cmd_pkg::DV_MODE_LOAD;
            dcount        <= MRD_CNT;
          end
        end
        // Low-power states held while enable stays low
        sdram_cmd_pkg::DV_POWER_DOWN:
          if (!cke_prev && cke_s2 && nop_like)
            dev_state_out <= sdram_cmd_pkg::DV_NORMAL;
        sdram_cmd_pkg::DV_SELF_REFRESH:
          if (!cke_prev && cke_s2 && nop_like)
          begin
            dev_state_out <= sdram_cmd_pkg::DV_SR_EXIT;
            dcount        <= XSR_CNT;
            nop_count     <= '0;
          end
        sdram_cmd_pkg::DV_SR_EXIT:
        begin
          if (cmd == sdram_cmd_pkg::CMD_NOP && nop_count != 3'h7)
            nop_count <= nop_count + 3'h1;
          if (dcount <= CNT_W'(1))
            dev_state_out <= sdram_cmd_pkg::DV_NORMAL;
        end
        // Command at the exit edge is ignored; next edge decodes
        sdram_cmd_pkg::DV_SUSPEND:
          if (!cke_prev && cke_s2)
            dev_state_out <= sdram_cmd_pkg::DV_NORMAL;
        default:
          if (dcount <= CNT_W'(1))
            dev_state_out <= sdram_cmd_pkg::DV_NORMAL;
      endcase
    end
  end

  // Most recent burst owner, for terminate
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
      last_burst_bank <= 2'h0;
    else if (live && (cmd == sdram_cmd_pkg::CMD_READ || cmd == sdram_cmd_pkg::CMD_WRITE))
      last_burst_bank <= ba_s2;
  end

  // Error flag for sequences the device cannot honour; sticky until reset
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
      protocol_error_out <= 1'b0;
    else if ((dev_state_out == sdram_cmd_pkg::DV_SR_EXIT && !nop_like) ||
             (dev_state_out == sdram_cmd_pkg::DV_SR_EXIT && dcount <= CNT_W'(1) &&
              (nop_count + 3'(cmd == sdram_cmd_pkg::CMD_NOP)) < MIN_NOPS) ||
             (live && (cmd == sdram_cmd_pkg::CMD_READ || cmd == sdram_cmd_pkg::CMD_WRITE) &&
              bank_idle_out[ba_s2]) ||
             ((dev_state_out == sdram_cmd_pkg::DV_REFRESHING ||
               dev_state_out == sdram_cmd_pkg::DV_MODE_LOAD) && !nop_like) ||
             (live && cmd == sdram_cmd_pkg::CMD_ILLEGAL) ||
             (live && (cmd == sdram_cmd_pkg::CMD_REFRESH ||
                       cmd == sdram_cmd_pkg::CMD_LOAD_MODE) && !all_idle) ||
             (live && cmd == sdram_cmd_pkg::CMD_PRECHARGE && a_s2[`AP_BIT] && any_busy))
      protocol_error_out <= 1'b1;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
      cmd_out <= sdram_cmd_pkg::CMD_INHIBIT;
    else
      cmd_out <= live ? cmd : sdram_cmd_pkg::CMD_INHIBIT;
  end

  for (genvar b = 0; b < BANKS; b++)
  begin : g_bank
    sdram_bank_fsm #(
      .CNT_W (CNT_W)
    ) u_bank (
      .ref_clk_in  (ref_clk_in),
      .srst_in     (srst_in),
      .live_in     (live),
      .cmd_in      (cmd),
      .hit_in      (ba_s2 == 2'(b)),
      .all_in      (a_s2[`AP_BIT]),
      .auto_pre_in (a_s2[`AP_BIT]),
      .term_in     (cmd == sdram_cmd_pkg::CMD_TERMINATE && last_burst_bank == 2'(b)),
      .state_out   (bank_st[b])
    );
    assign bank_idle_out[b] = (bank_st[b] == sdram_cmd_pkg::BK_IDLE);
  end
endmodule

// File: core/sdram_cmd_controller.sv
// Controller end: drives pins from a user request, honouring wait intervals
`timescale 1ns/100ps
`include "sdram_cmd_params.svh"
module sdram_cmd_controller #(
  parameter int CNT_W = `CNT_W
) (
  input  wire logic                 ref_clk_in,
  input  wire logic                 srst_in,
  input  wire logic                 req_valid_in,
  input  wire sdram_cmd_pkg::cmd_t  req_cmd_in,
  input  wire logic [1:0]           req_bank_in,
  input  wire logic [11:0]          req_addr_in,
  input  wire logic                 req_cke_in,
  output      logic                 req_ready_out,
  sdram_cmd_if.controller           link
);
  logic [CNT_W-1:0] wait_count;
  logic [CNT_W-1:0] next_wait;
  logic             cke_prev;

  // Interval each command imposes before the next, rounded up
  always_comb
  begin
    case (req_cmd_in)
      sdram_cmd_pkg::CMD_PRECHARGE: next_wait = CNT_W'(`PRECHARGE_CYC);
      sdram_cmd_pkg::CMD_ACTIVE:    next_wait = CNT_W'(`ACT_ACCESS_CYC);
      sdram_cmd_pkg::CMD_REFRESH:   next_wait = CNT_W'(`REFRESH_CYCLE_CYC);
      sdram_cmd_pkg::CMD_LOAD_MODE: next_wait = CNT_W'(`MODE_LOAD_CYC);
      default:                      next_wait = '0;
    endcase
    // Any enable rise with a request taken: wait out self refresh exit time with no-ops
    if (!cke_prev && req_cke_in)
      next_wait = CNT_W'(`SELF_REF_EXIT_CYC);
  end

  // Conservative: global wait covers any bank; no request, no-op included, is taken until it ends
  assign req_ready_out = (wait_count == '0);

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      wait_count           <= '0;
      cke_prev             <= 1'b0;
      link.clock_enable    <= 1'b0;
      link.chip_select_n   <= 1'b1;
      link.row_strobe_n    <= 1'b1;
      link.column_strobe_n <= 1'b1;
      link.write_enable_n  <= 1'b1;
      link.bank_addr       <= 2'h0;
      link.addr            <= 12'h000;
    end
    else
    begin
      cke_prev          <= link.clock_enable;
      link.clock_enable <= req_cke_in;
      if (wait_count != '0)
        wait_count <= wait_count - CNT_W'(1);
      // No-op while waiting or idle
      {link.chip_select_n, link.row_strobe_n, link.column_strobe_n,
       link.write_enable_n} <= 4'h7;
      if (req_valid_in && req_ready_out)
      begin
        wait_count     <= next_wait;
        link.bank_addr <= req_bank_in;
        link.addr      <= req_addr_in;
        case (req_cmd_in)
          sdram_cmd_pkg::CMD_INHIBIT:   link.chip_select_n <= 1'b1;
          sdram_cmd_pkg::CMD_ACTIVE:    {link.chip_select_n, link.row_strobe_n,
                                         link.column_strobe_n, link.write_enable_n} <= 4'h3;
          sdram_cmd_pkg::CMD_READ:      {link.chip_select_n, link.row_strobe_n,
                                         link.column_strobe_n, link.write_enable_n} <= 4'h5;
          sdram_cmd_pkg::CMD_WRITE:     {link.chip_select_n, link.row_strobe_n,
                                         link.column_strobe_n, link.write_enable_n} <= 4'h4;
          sdram_cmd_pkg::CMD_PRECHARGE: {link.chip_select_n, link.row_strobe_n,
                                         link.column_strobe_n, link.write_enable_n} <= 4'h2;
          sdram_cmd_pkg::CMD_REFRESH:   {link.chip_select_n, link.row_strobe_n,
                                         link.column_strobe_n, link.write_enable_n} <= 4'h1;
          sdram_cmd_pkg::CMD_LOAD_MODE: {link.chip_select_n, link.row_strobe_n,
                                         link.column_strobe_n, link.write_enable_n} <= 4'h0;
          sdram_cmd_pkg::CMD_TERMINATE: {link.chip_select_n, link.row_strobe_n,
                                         link.column_strobe_n, link.write_enable_n} <= 4'h6;
          default:                      {link.chip_select_n, link.row_strobe_n,
                                         link.column_strobe_n, link.write_enable_n} <= 4'h7;
        endcase
      end
    end
  end
endmodule

// File: sim/sdram_command_state_control_asserts.sv
// Pin-level checks on the command link
`timescale 1ns/100ps
module sdram_command_state_control_asserts (
  input wire logic        ref_clk_in,
  input wire logic        srst_in,
  input wire logic        clock_enable,
  input wire logic        chip_select_n,
  input wire logic        row_strobe_n,
  input wire logic        column_strobe_n,
  input wire logic        write_enable_n,
  input wire logic [1:0]  bank_addr,
  input wire logic [11:0] addr
);
  logic       cke_prev;
  logic       in_sr;
  logic [3:0] open_rows;
  logic       live, quiet, sel, is_act, is_rd, is_wr, is_pre, is_ref, is_mode;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);

  // Pin decode
  assign sel     = !chip_select_n;
  assign quiet   = chip_select_n | (row_strobe_n & column_strobe_n & write_enable_n);
  assign is_act  = sel & !row_strobe_n & column_strobe_n & write_enable_n;
  assign is_ref  = sel & !row_strobe_n & !column_strobe_n & write_enable_n;
  assign is_mode = sel & !row_strobe_n & !column_strobe_n & !write_enable_n;
  assign is_pre  = sel & !row_strobe_n & column_strobe_n & !write_enable_n;
  assign is_rd   = sel & row_strobe_n & !column_strobe_n & write_enable_n;
  assign is_wr   = sel & row_strobe_n & !column_strobe_n & !write_enable_n;
  assign live    = clock_enable & cke_prev;

  // Enable history
  always_ff @(posedge ref_clk_in)
    if (srst_in)
      cke_prev <= 1'b0;
    else
      cke_prev <= clock_enable;

  // Self refresh from pins
  always_ff @(posedge ref_clk_in)
    if (srst_in)
      in_sr <= 1'b0;
    else if (cke_prev && !clock_enable && is_ref)
      in_sr <= 1'b1;
    else if (clock_enable)
      in_sr <= 1'b0;

  // Open rows from the pins
  always_ff @(posedge ref_clk_in)
    if (srst_in)
      open_rows <= 4'h0;
    else if (live && is_act)
      open_rows[bank_addr] <= 1'b1;
    else if (live && is_pre && addr[10])
      open_rows <= 4'h0;
    else if (live && (is_pre || ((is_rd || is_wr) && addr[10])))
      open_rows[bank_addr] <= 1'b0;

  property p_refresh_quiet;
    live && is_ref |=> quiet;
  endproperty
  a_refresh_quiet: assert property (p_refresh_quiet) else $error("command inside refresh");

  property p_sr_exit_quiet;
    in_sr && $rose(clock_enable) |-> quiet ##1 quiet;
  endproperty
  a_sr_exit_quiet: assert property (p_sr_exit_quiet) else $error("command inside exit");

  property p_refresh_idle;
    is_ref && cke_prev |-> open_rows == 4'h0;
  endproperty
  a_refresh_idle: assert property (p_refresh_idle) else $error("refresh with open row");

  property p_mode_idle;
    live && is_mode |-> open_rows == 4'h0;
  endproperty
  a_mode_idle: assert property (p_mode_idle) else $error("mode load with open row");

  property p_rw_open;
    live && (is_rd || is_wr) |-> open_rows[bank_addr];
  endproperty
  a_rw_open: assert property (p_rw_open) else $error("access to closed bank");

  property p_act_closed;
    live && is_act |-> !open_rows[bank_addr];
  endproperty
  a_act_closed: assert property (p_act_closed) else $error("activate on open bank");

  property p_pd_entry;
    $fell(clock_enable) && open_rows == 4'h0 |-> quiet || is_ref;
  endproperty
  a_pd_entry: assert property (p_pd_entry) else $error("bad low power entry");

  property p_ref_high;
    is_ref |-> $past(clock_enable);
  endproperty
  a_ref_high: assert property (p_ref_high) else $error("refresh after low enable");
endmodule

// File: sim/sdram_command_state_control_tb.sv
// Bench for both ends of the command link
`timescale 1ns/100ps
module sdram_command_state_control_tb;
  logic                      ref_clk_in = 1'b0;
  logic                      srst_in;
  logic                      req_valid_in;
  sdram_cmd_pkg::cmd_t       req_cmd_in;
  logic [1:0]                req_bank_in;
  logic [11:0]               req_addr_in;
  logic                      req_cke_in;
  logic                      req_ready_out;
  sdram_cmd_pkg::dev_state_t dev_state_out;
  sdram_cmd_pkg::cmd_t       cmd_out;
  logic [3:0]                bank_idle_out;
  logic                      protocol_error_out;
  logic                      fault_error;
  int                        bad_count = 0;
  int                        check_count = 0;

  sdram_cmd_if link();
  sdram_cmd_if link_b();

  sdram_cmd_controller i_sdram_cmd_controller (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
    .req_valid_in(req_valid_in), .req_cmd_in(req_cmd_in), .req_bank_in(req_bank_in),
    .req_addr_in(req_addr_in), .req_cke_in(req_cke_in), .req_ready_out(req_ready_out),
    .link(link));
  sdram_cmd_device i_sdram_cmd_device (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
    .link(link), .dev_state_out(dev_state_out), .cmd_out(cmd_out),
    .bank_idle_out(bank_idle_out), .protocol_error_out(protocol_error_out));
  // Second device on bench-driven pins
  sdram_cmd_device i_sdram_cmd_device_b (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
    .link(link_b), .dev_state_out(), .cmd_out(), .bank_idle_out(),
    .protocol_error_out(fault_error));
  sdram_command_state_control_asserts i_sdram_command_state_control_asserts (
    .ref_clk_in(ref_clk_in), .srst_in(srst_in), .clock_enable(link.clock_enable),
    .chip_select_n(link.chip_select_n), .row_strobe_n(link.row_strobe_n),
    .column_strobe_n(link.column_strobe_n), .write_enable_n(link.write_enable_n),
    .bank_addr(link.bank_addr), .addr(link.addr));

  always #25 ref_clk_in = ~ref_clk_in;

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic send(input sdram_cmd_pkg::cmd_t c, input logic [1:0] b,
                      input logic [11:0] a, input logic k);
    int n = 0;
    @(negedge ref_clk_in);
    {req_valid_in, req_cmd_in, req_bank_in, req_addr_in, req_cke_in} = {1'b1, c, b, a, k};
    do
    begin
      @(posedge ref_clk_in);
      n++;
    end
    while (req_ready_out !== 1'b1 && n < 40);
    chk("request taken", 8'(n < 40), 8'h01);
    @(negedge ref_clk_in);
    req_valid_in = 1'b0;
  endtask

  task automatic issue(input sdram_cmd_pkg::cmd_t c, input logic [1:0] b, input logic [11:0] a);
    send(c, b, a, 1'b1);
    repeat (3) @(posedge ref_clk_in);
    @(negedge ref_clk_in);
    chk("decoded command", cmd_out, c);
  endtask

  task automatic wait_dev(input sdram_cmd_pkg::dev_state_t s, input int lim);
    int n = 0;
    while (dev_state_out !== s && n < lim)
    begin
      @(negedge ref_clk_in);
      n++;
    end
    chk("device state", dev_state_out, s);
  endtask

  task automatic t_reset();
    chk("select pin", link.chip_select_n, 1'b1);
    chk("banks idle", bank_idle_out, 4'hF);
    chk("device state", dev_state_out, sdram_cmd_pkg::DV_NORMAL);
  endtask

  task automatic t_rw();
    for (int b = 0; b < 4; b++)
    begin
      issue(sdram_cmd_pkg::CMD_ACTIVE, 2'(b), 12'h123);
      chk("bank open", bank_idle_out[b], 1'b0);
      issue(sdram_cmd_pkg::CMD_READ, 2'(b), 12'h010);
      issue(sdram_cmd_pkg::CMD_NOP, 2'(b), 12'h000);
      issue(sdram_cmd_pkg::CMD_WRITE, 2'(b), 12'h020);
      issue(sdram_cmd_pkg::CMD_READ, 2'(b), 12'h030);
      issue(sdram_cmd_pkg::CMD_TERMINATE, 2'(b), 12'h000);
      issue(sdram_cmd_pkg::CMD_WRITE, 2'(b), 12'h040);
      issue(sdram_cmd_pkg::CMD_PRECHARGE, 2'(b), 12'h000);
      @(negedge ref_clk_in);
      chk("bank closed", bank_idle_out[b], 1'b1);
    end
  endtask

  task automatic t_auto_pre();
    for (int i = 0; i < 2; i++)
    begin
      issue(sdram_cmd_pkg::CMD_ACTIVE, 2'h0, 12'h001);
      issue(i ? sdram_cmd_pkg::CMD_WRITE : sdram_cmd_pkg::CMD_READ, 2'h0, 12'h400);
      repeat (2) @(negedge ref_clk_in);
      chk("auto precharge idle", bank_idle_out, 4'hF);
    end
    issue(sdram_cmd_pkg::CMD_ACTIVE, 2'h1, 12'h002);
    issue(sdram_cmd_pkg::CMD_ACTIVE, 2'h2, 12'h003);
    issue(sdram_cmd_pkg::CMD_PRECHARGE, 2'h0, 12'h400);
    @(negedge ref_clk_in);
    chk("all banks idle", bank_idle_out, 4'hF);
    issue(sdram_cmd_pkg::CMD_PRECHARGE, 2'h3, 12'h000);
    chk("idle bank kept", bank_idle_out, 4'hF);
  endtask

  task automatic t_refresh_mode();
    issue(sdram_cmd_pkg::CMD_REFRESH, 2'h0, 12'h000);
    chk("refreshing", dev_state_out, sdram_cmd_pkg::DV_REFRESHING);
    wait_dev(sdram_cmd_pkg::DV_NORMAL, 4);
    issue(sdram_cmd_pkg::CMD_LOAD_MODE, 2'h0, 12'h030);
    chk("mode load", dev_state_out, sdram_cmd_pkg::DV_MODE_LOAD);
    wait_dev(sdram_cmd_pkg::DV_NORMAL, 4);
  endtask

  task automatic t_low_power();
    req_cke_in = 1'b0;
    wait_dev(sdram_cmd_pkg::DV_POWER_DOWN, 8);
    repeat (4) @(negedge ref_clk_in);
    chk("held down", dev_state_out, sdram_cmd_pkg::DV_POWER_DOWN);
    chk("no decode", cmd_out, sdram_cmd_pkg::CMD_INHIBIT);
    req_cke_in = 1'b1;
    wait_dev(sdram_cmd_pkg::DV_NORMAL, 8);
    issue(sdram_cmd_pkg::CMD_ACTIVE, 2'h2, 12'h004);
    issue(sdram_cmd_pkg::CMD_PRECHARGE, 2'h2, 12'h000);
    send(sdram_cmd_pkg::CMD_REFRESH, 2'h0, 12'h000, 1'b0);
    wait_dev(sdram_cmd_pkg::DV_SELF_REFRESH, 8);
    repeat (4) @(negedge ref_clk_in);
    chk("held refresh", dev_state_out, sdram_cmd_pkg::DV_SELF_REFRESH);
    req_cke_in = 1'b1;
    wait_dev(sdram_cmd_pkg::DV_SR_EXIT, 6);
    wait_dev(sdram_cmd_pkg::DV_NORMAL, 6);
    issue(sdram_cmd_pkg::CMD_ACTIVE, 2'h1, 12'h005);
    issue(sdram_cmd_pkg::CMD_WRITE, 2'h1, 12'h006);
    req_cke_in = 1'b0;
    wait_dev(sdram_cmd_pkg::DV_SUSPEND, 8);
    repeat (3) @(negedge ref_clk_in);
    chk("held suspend", dev_state_out, sdram_cmd_pkg::DV_SUSPEND);
    req_cke_in = 1'b1;
    wait_dev(sdram_cmd_pkg::DV_NORMAL, 8);
    issue(sdram_cmd_pkg::CMD_TERMINATE, 2'h1, 12'h000);
    issue(sdram_cmd_pkg::CMD_PRECHARGE, 2'h1, 12'h000);
  endtask

  task automatic t_fault();
    chk("fault flag clear", fault_error, 1'b0);
    link_b.chip_select_n = 1'b0;
    link_b.column_strobe_n = 1'b0;
    @(negedge ref_clk_in);
    link_b.chip_select_n = 1'b1;
    link_b.column_strobe_n = 1'b1;
    repeat (5) @(negedge ref_clk_in);
    chk("fault flag set", fault_error, 1'b1);
  endtask

  initial
  begin
    repeat (4000) @(posedge ref_clk_in);
    bad_count++;
    print_verdict();
  end

  initial
  begin
    {srst_in, req_valid_in, req_bank_in, req_addr_in, req_cke_in} = {4'b1000, 12'h000, 1'b1};
    req_cmd_in = sdram_cmd_pkg::CMD_NOP;
    {link_b.clock_enable, link_b.chip_select_n, link_b.row_strobe_n} = 3'b111;
    {link_b.column_strobe_n, link_b.write_enable_n, link_b.bank_addr, link_b.addr} = 16'hC000;
    repeat (10) @(negedge ref_clk_in);
    srst_in = 1'b0;
    t_reset();
    t_rw();
    t_auto_pre();
    t_refresh_mode();
    t_low_power();
    t_fault();
    chk("link error flag", protocol_error_out, 1'b0);
    print_verdict();
  end
endmodule
